// ==== rtl/lcp_pkg.sv ====
package lcp_pkg;

  localparam longint unsigned CLK_HZ = 64'd250_000_000;

  // Delay figures in microseconds
  localparam longint unsigned T_OC_DET_US = 64'd1_000_000;
  localparam longint unsigned T_OC_REL_US = 64'd16_000;
  localparam longint unsigned T_OD_DET_US = 64'd20_000;
  localparam longint unsigned T_OD_REL_US = 64'd1_200;
  localparam longint unsigned T_DOC_DET_US = 64'd12_000;
  localparam longint unsigned T_DOC_REL_US = 64'd1_200;
  localparam longint unsigned T_SC_DET_US = 64'd300;
  localparam longint unsigned T_COC_DET_US = 64'd8_000;
  localparam longint unsigned T_COC_REL_US = 64'd1_200;

  // Shortened delays divide by this factor
  localparam int unsigned DS_DIV = 60;

  localparam int unsigned CW = 32;

  localparam logic [CW-1:0] OC_DET_CYC = CW'(T_OC_DET_US * CLK_HZ / 64'd1_000_000);
  localparam logic [CW-1:0] OC_REL_CYC = CW'(T_OC_REL_US * CLK_HZ / 64'd1_000_000);
  localparam logic [CW-1:0] OD_DET_CYC = CW'(T_OD_DET_US * CLK_HZ / 64'd1_000_000);
  localparam logic [CW-1:0] OD_REL_CYC = CW'(T_OD_REL_US * CLK_HZ / 64'd1_000_000);
  localparam logic [CW-1:0] DOC_DET_CYC = CW'(T_DOC_DET_US * CLK_HZ / 64'd1_000_000);
  localparam logic [CW-1:0] DOC_REL_CYC = CW'(T_DOC_REL_US * CLK_HZ / 64'd1_000_000);
  localparam logic [CW-1:0] SC_DET_CYC = CW'(T_SC_DET_US * CLK_HZ / 64'd1_000_000);
  localparam logic [CW-1:0] COC_DET_CYC = CW'(T_COC_DET_US * CLK_HZ / 64'd1_000_000);
  localparam logic [CW-1:0] COC_REL_CYC = CW'(T_COC_REL_US * CLK_HZ / 64'd1_000_000);

  // Comparator results from the analog front end
  typedef struct packed {
    logic cell_ge_oc;     // Cell at or above overcharge_threshold
    logic cell_le_ocrel;  // Cell at or below overcharge release level
    logic cell_lt_od;     // Cell below overdischarge_threshold
    logic cell_ge_odrel;  // Cell at or above overdischarge release level
    logic vm_ge_doc;      // Charger-negative at or above discharge current level
    logic vm_ge_short;    // Charger-negative at or above short level
    logic vm_le_coc;      // Charger-negative at or below charge current level
    logic vm_le_ds;       // Charger-negative at or below delay_shorten_mode level
    logic charger_on;     // Charger present
    logic load_on;        // Load present, no charger
    logic zero_v_chg;     // Depleted cell, charger above 0V-charge level
  } lcp_cmp_t;

  typedef struct packed {
    logic chg_on;
    logic dis_on;
    logic rel_res_en;
    logic standby;
  } lcp_out_t;

  typedef enum logic [1:0] {
    LCP_DIS_NORM,
    LCP_DIS_OD,
    LCP_DIS_OCUR
  } lcp_dis_t;

endpackage

// ==== rtl/lcp_protect.sv ====
`timescale 1ns/1ps
module lcp_protect #(
  parameter logic [lcp_pkg::CW-1:0] OC_DET = lcp_pkg::OC_DET_CYC,
  parameter logic [lcp_pkg::CW-1:0] OC_REL = lcp_pkg::OC_REL_CYC,
  parameter logic [lcp_pkg::CW-1:0] OD_DET = lcp_pkg::OD_DET_CYC,
  parameter logic [lcp_pkg::CW-1:0] OD_REL = lcp_pkg::OD_REL_CYC,
  parameter logic [lcp_pkg::CW-1:0] DOC_DET = lcp_pkg::DOC_DET_CYC,
  parameter logic [lcp_pkg::CW-1:0] DOC_REL = lcp_pkg::DOC_REL_CYC,
  parameter logic [lcp_pkg::CW-1:0] SC_DET = lcp_pkg::SC_DET_CYC,
  parameter logic [lcp_pkg::CW-1:0] COC_DET = lcp_pkg::COC_DET_CYC,
  parameter logic [lcp_pkg::CW-1:0] COC_REL = lcp_pkg::COC_REL_CYC,
  parameter int unsigned DS_DIV = lcp_pkg::DS_DIV
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire lcp_pkg::lcp_cmp_t cmp_in,
  output lcp_pkg::lcp_out_t prot_out
);

  // A zero count would latch on the first sampled cycle with no filtering
  initial begin
    if (OC_DET == '0) begin
      $error("lcp_protect: OC_DET must be nonzero");
    end
    if (OC_REL == '0) begin
      $error("lcp_protect: OC_REL must be nonzero");
    end
    if (OD_DET == '0) begin
      $error("lcp_protect: OD_DET must be nonzero");
    end
    if (OD_REL == '0) begin
      $error("lcp_protect: OD_REL must be nonzero");
    end
    if (DOC_DET == '0) begin
      $error("lcp_protect: DOC_DET must be nonzero");
    end
    if (DOC_REL == '0) begin
      $error("lcp_protect: DOC_REL must be nonzero");
    end
    if (SC_DET == '0) begin
      $error("lcp_protect: SC_DET must be nonzero");
    end
    if (COC_DET == '0) begin
      $error("lcp_protect: COC_DET must be nonzero");
    end
    if (COC_REL == '0) begin
      $error("lcp_protect: COC_REL must be nonzero");
    end
    if (DS_DIV == 0) begin
      $error("lcp_protect: DS_DIV must be nonzero");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers: comparators are asynchronous to core_clk

  localparam int unsigned NB = $bits(lcp_pkg::lcp_cmp_t);
  logic [NB-1:0] s1_q, s1_d;
  logic [NB-1:0] s2_q, s2_d;
  lcp_pkg::lcp_cmp_t c;

  always_comb begin
    s1_d = cmp_in;
    s2_d = s1_q;
    c = s2_q;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delay shortening limits

  function automatic logic [lcp_pkg::CW-1:0] shrt(input logic [lcp_pkg::CW-1:0] v);
    logic [lcp_pkg::CW-1:0] r;
    r = v / lcp_pkg::CW'(DS_DIV);
    shrt = (r == '0) ? lcp_pkg::CW'(1) : r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State and counters

  logic oc_q, oc_d;
  logic coc_q, coc_d;
  lcp_pkg::lcp_dis_t dis_q, dis_d;
  logic [lcp_pkg::CW-1:0] occ_q, occ_d;
  logic [lcp_pkg::CW-1:0] odc_q, odc_d;
  logic [lcp_pkg::CW-1:0] docc_q, docc_d;
  logic [lcp_pkg::CW-1:0] scc_q, scc_d;
  logic [lcp_pkg::CW-1:0] cocc_q, cocc_d;
  lcp_pkg::lcp_out_t out_q, out_d;

  logic ds;
  logic oc_cond, od_cond, doc_cond, sc_cond, coc_cond;
  logic [lcp_pkg::CW-1:0] oc_lim, od_lim;

  // Gated on registered charge control to avoid a loop through out_d
  always_comb begin
    ds = out_q.chg_on && c.vm_le_ds;
  end

  ////////////////////////////////////////////////////////////////////////
  // Overcharge group

  always_comb begin
    oc_d = oc_q;
    occ_d = '0;
    oc_lim = '0;
    // Charge side: overcharge detector
    if (!oc_q) begin
      oc_cond = c.cell_ge_oc;
      oc_lim = ds ? shrt(OC_DET) : OC_DET;
      if (oc_cond && dis_q != lcp_pkg::LCP_DIS_OD) begin
        occ_d = occ_q + lcp_pkg::CW'(1);
        if (occ_d >= oc_lim) begin
          oc_d = 1'b1;
          occ_d = '0;
        end
      end // Counter cleared when the crossing drops
    end else begin
      // load with cell still high gives no release
      oc_cond = c.cell_le_ocrel || (c.load_on && !c.cell_ge_oc);
      if (oc_cond) begin
        occ_d = occ_q + lcp_pkg::CW'(1);
        if (occ_d >= OC_REL) begin
          oc_d = 1'b0;
          occ_d = '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Charge overcurrent group

  always_comb begin
    coc_d = coc_q;
    cocc_d = '0;
    // Charge side: charge overcurrent detector
    if (!coc_q) begin
      coc_cond = c.vm_le_coc && dis_q == lcp_pkg::LCP_DIS_NORM;
      if (coc_cond) begin
        cocc_d = cocc_q + lcp_pkg::CW'(1);
        if (cocc_d >= COC_DET) begin
          coc_d = 1'b1;
          cocc_d = '0;
        end
      end
    end else begin
      coc_cond = c.load_on && !c.charger_on;
      if (coc_cond) begin
        cocc_d = cocc_q + lcp_pkg::CW'(1);
        if (cocc_d >= COC_REL) begin
          coc_d = 1'b0;
          cocc_d = '0;
        end
      end
    end

  end

  ////////////////////////////////////////////////////////////////////////
  // Discharge group

  always_comb begin
    dis_d = dis_q;
    odc_d = '0;
    docc_d = '0;
    scc_d = '0;
    od_lim = '0;
    // Discharge side
    od_cond = 1'b0;
    doc_cond = 1'b0;
    sc_cond = 1'b0;
    case (dis_q)
      lcp_pkg::LCP_DIS_NORM: begin
        od_cond = c.cell_lt_od;
        sc_cond = c.vm_ge_short;
        doc_cond = c.vm_ge_doc && !c.vm_ge_short;
        od_lim = ds ? shrt(OD_DET) : OD_DET;
        if (od_cond) begin
          odc_d = odc_q + lcp_pkg::CW'(1);
        end
        if (doc_cond) begin
          docc_d = docc_q + lcp_pkg::CW'(1);
        end
        if (sc_cond) begin
          scc_d = scc_q + lcp_pkg::CW'(1);
        end
        // Current faults checked first so they govern
        if ((sc_cond && scc_d >= SC_DET) || (doc_cond && docc_d >= DOC_DET)) begin
          dis_d = lcp_pkg::LCP_DIS_OCUR;
          odc_d = '0;
          docc_d = '0;
          scc_d = '0;
        end else if (od_cond && odc_d >= od_lim) begin
          dis_d = lcp_pkg::LCP_DIS_OD;
          odc_d = '0;
          docc_d = '0;
          scc_d = '0;
        end
      end
      lcp_pkg::LCP_DIS_OD: begin
        // Only release logic runs in standby
        od_cond = c.charger_on ? !c.cell_lt_od : c.cell_ge_odrel;
        od_lim = ds ? shrt(OD_REL) : OD_REL;
        if (od_cond) begin
          odc_d = odc_q + lcp_pkg::CW'(1);
          if (odc_d >= od_lim) begin
            dis_d = lcp_pkg::LCP_DIS_NORM;
            odc_d = '0;
          end
        end
      end
      lcp_pkg::LCP_DIS_OCUR: begin
        if (!c.vm_ge_doc) begin
          docc_d = docc_q + lcp_pkg::CW'(1);
          if (docc_d >= DOC_REL) begin
            dis_d = lcp_pkg::LCP_DIS_NORM;
            docc_d = '0;
          end
        end
      end
      default: begin
        dis_d = lcp_pkg::LCP_DIS_NORM;
      end
    endcase

  end

  ////////////////////////////////////////////////////////////////////////
  // Output group

  always_comb begin
    // Depleted cell with charger may charge regardless of latches
    out_d.chg_on = c.zero_v_chg || (!oc_d && !coc_d);
    out_d.dis_on = dis_d == lcp_pkg::LCP_DIS_NORM;
    out_d.rel_res_en = dis_d == lcp_pkg::LCP_DIS_OCUR;
    out_d.standby = dis_d == lcp_pkg::LCP_DIS_OD;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      oc_q <= 1'b0;
      occ_q <= '0;
    end else begin
      oc_q <= oc_d;
      occ_q <= occ_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      coc_q <= 1'b0;
      cocc_q <= '0;
    end else begin
      coc_q <= coc_d;
      cocc_q <= cocc_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dis_q <= lcp_pkg::LCP_DIS_NORM;
      odc_q <= '0;
      docc_q <= '0;
      scc_q <= '0;
    end else begin
      dis_q <= dis_d;
      odc_q <= odc_d;
      docc_q <= docc_d;
      scc_q <= scc_d;
    end
  end

  // Both controls on after reset: protection waits for filtered inputs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      out_q <= 4'hC;
    end else begin
      out_q <= out_d;
    end
  end

  always_comb begin
    prot_out = out_q;
  end

endmodule

// ==== test/lcp_cell_model.sv ====
`timescale 1ns/1ps
// Cell, charger and load seen through ideal comparators
module lcp_cell_model (
  input wire logic [15:0] cell_mv,
  input wire logic signed [15:0] vm_mv,
  input wire logic chg_att,
  input wire logic load_att,
  output lcp_pkg::lcp_cmp_t cmp
);
  // No hysteresis here; the block must supply its own filtering
  always_comb begin
    cmp.cell_ge_oc = cell_mv >= 16'h109A;
    cmp.cell_le_ocrel = cell_mv <= 16'h0FD2;
    cmp.cell_lt_od = cell_mv < 16'h09C4;
    cmp.cell_ge_odrel = cell_mv >= 16'h0BB8;
    cmp.vm_ge_doc = vm_mv >= 16'sh00C8;
    cmp.vm_ge_short = vm_mv >= 16'sh0320;
    cmp.vm_le_coc = vm_mv <= -16'sh0064;
    cmp.vm_le_ds = vm_mv <= -16'sh07D0;
    cmp.charger_on = chg_att;
    cmp.load_on = load_att && !chg_att;
    cmp.zero_v_chg = (cell_mv == 16'h0000) && chg_att;
  end
endmodule

// ==== test/lcp_protect_chk.sv ====
`timescale 1ns/1ps
module lcp_protect_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire lcp_pkg::lcp_cmp_t cmp_in,
  input wire lcp_pkg::lcp_out_t prot_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  property p_res;
    prot_out.rel_res_en |-> !prot_out.dis_on;
  endproperty
  a_res: assert property (p_res) else $error("release resistor on in normal mode");
  property p_chg_fall;
    $fell(prot_out.chg_on) |-> $past(cmp_in.cell_ge_oc | cmp_in.vm_le_coc, 3)
      | $past(cmp_in.zero_v_chg, 4);
  endproperty
  a_chg_fall: assert property (p_chg_fall) else $error("charge off without cause");
  property p_dis_fall;
    $fell(prot_out.dis_on) |-> $past(cmp_in.cell_lt_od | cmp_in.vm_ge_doc, 3);
  endproperty
  a_dis_fall: assert property (p_dis_fall) else $error("discharge off without cause");
  property p_stby;
    prot_out.standby |-> !prot_out.dis_on;
  endproperty
  a_stby: assert property (p_stby) else $error("standby with discharge on");
  property p_zero;
    cmp_in.zero_v_chg [*5] |-> prot_out.chg_on;
  endproperty
  a_zero: assert property (p_zero) else $error("depleted cell charge blocked");
  property p_dis_rise;
    $rose(prot_out.dis_on) |-> $past(cmp_in.cell_ge_odrel | cmp_in.charger_on
      & !cmp_in.cell_lt_od | !cmp_in.vm_ge_doc, 3);
  endproperty
  a_dis_rise: assert property (p_dis_rise) else $error("discharge on without cause");
  property p_chg_rise;
    $rose(prot_out.chg_on) |-> $past(!cmp_in.cell_ge_oc | cmp_in.load_on
      | cmp_in.zero_v_chg, 3);
  endproperty
  a_chg_rise: assert property (p_chg_rise) else $error("charge on without cause");
  property p_res_fall;
    $fell(prot_out.rel_res_en) |-> $past(!cmp_in.vm_ge_doc, 3);
  endproperty
  a_res_fall: assert property (p_res_fall) else $error("current fault left early");
  c_oc: cover property ($fell(prot_out.chg_on));
  c_od: cover property ($rose(prot_out.standby));
  c_cur: cover property ($rose(prot_out.rel_res_en));
endmodule
bind lcp_protect lcp_protect_chk i_lcp_protect_chk (.core_clk(core_clk), .nrst(nrst),
  .cmp_in(cmp_in), .prot_out(prot_out));

// ==== test/test_li_cell_protection_logic.sv ====
`timescale 1ns/1ps
module test_li_cell_protection_logic;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic [15:0] cell_mv = 16'h0ED8;
  logic signed [15:0] vm_mv = 16'sh0000;
  logic chg_att = 1'h0;
  logic load_att = 1'h1;
  lcp_pkg::lcp_cmp_t cmp;
  lcp_pkg::lcp_out_t po;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  always #2 core_clk = ~core_clk;
  lcp_cell_model i_lcp_cell_model (.cell_mv(cell_mv), .vm_mv(vm_mv), .chg_att(chg_att),
    .load_att(load_att), .cmp(cmp));
  // Short counts keep the run small; DS_DIV 4 leaves OC_DET and OD_DET above 1 but cuts OD_REL to 1
  localparam logic [31:0] N_OC_DET = 32'h14;
  localparam logic [31:0] N_OC_REL = 32'h8;
  localparam logic [31:0] N_OD_DET = 32'hC;
  localparam logic [31:0] N_OD_REL = 32'h4;
  localparam logic [31:0] N_DOC_DET = 32'hA;
  localparam logic [31:0] N_DOC_REL = 32'h4;
  localparam logic [31:0] N_SC_DET = 32'h3;
  localparam logic [31:0] N_COC_DET = 32'h6;
  localparam logic [31:0] N_COC_REL = 32'h4;
  localparam int unsigned N_DS_DIV = 4;
  lcp_protect #(.OC_DET(N_OC_DET), .OC_REL(N_OC_REL), .OD_DET(N_OD_DET), .OD_REL(N_OD_REL),
    .DOC_DET(N_DOC_DET), .DOC_REL(N_DOC_REL), .SC_DET(N_SC_DET), .COC_DET(N_COC_DET),
    .COC_REL(N_COC_REL), .DS_DIV(N_DS_DIV)) i_lcp_protect (.core_clk(core_clk), .nrst(nrst),
    .cmp_in(cmp), .prot_out(po));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic drv(input logic [15:0] c, input logic signed [15:0] v, input logic ch,
    input logic ld, input int n);
    @(posedge core_clk);
    cell_mv <= c;
    vm_mv <= v;
    chg_att <= ch;
    load_att <= ld;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rst();
    @(posedge core_clk);
    nrst <= 1'h0;
    drv(16'h0ED8, 16'sh0000, 1'h0, 1'h1, 2);
    @(posedge core_clk);
    nrst <= 1'h1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_oc();
    drv(16'h10CC, 16'sh0000, 1'h1, 1'h0, 10);
    drv(16'h1004, 16'sh0000, 1'h1, 1'h0, 5);
    chk("chg glitch", po.chg_on, 1'h1);
    drv(16'h10CC, 16'sh0000, 1'h1, 1'h0, 30);
    chk("chg oc", po.chg_on, 1'h0);
    drv(16'h1004, 16'sh0000, 1'h1, 1'h0, 20);
    chk("chg above rel", po.chg_on, 1'h0);
    drv(16'h10CC, 16'sh0000, 1'h0, 1'h1, 20);
    chk("chg load high cell", po.chg_on, 1'h0);
    drv(16'h0FA0, 16'sh0000, 1'h1, 1'h0, 4);
    drv(16'h1004, 16'sh0000, 1'h1, 1'h0, 4);
    chk("chg short rel", po.chg_on, 1'h0);
    drv(16'h0FA0, 16'sh0000, 1'h1, 1'h0, 15);
    chk("chg rel", po.chg_on, 1'h1);
  endtask
  task automatic t_od();
    drv(16'h0960, 16'sh0000, 1'h0, 1'h1, 8);
    drv(16'h0DAC, 16'sh0000, 1'h0, 1'h1, 5);
    chk("dis glitch", po.dis_on, 1'h1);
    drv(16'h0960, 16'sh0000, 1'h0, 1'h1, 25);
    chk("dis od", po.dis_on, 1'h0);
    chk("standby", po.standby, 1'h1);
    drv(16'h0AF0, 16'sh0000, 1'h0, 1'h1, 20);
    chk("dis no charger", po.dis_on, 1'h0);
    drv(16'h0AF0, 16'sh0000, 1'h1, 1'h0, 12);
    chk("dis charger rel", po.dis_on, 1'h1);
  endtask
  task automatic t_doc();
    drv(16'h0ED8, 16'sh012C, 1'h0, 1'h1, 5);
    drv(16'h0ED8, 16'sh0000, 1'h0, 1'h1, 5);
    chk("dis doc glitch", po.dis_on, 1'h1);
    drv(16'h0960, 16'sh012C, 1'h0, 1'h1, 20);
    chk("dis doc", po.dis_on, 1'h0);
    chk("res doc", po.rel_res_en, 1'h1);
    drv(16'h0ED8, 16'sh0000, 1'h0, 1'h1, 12);
    chk("dis doc rel", po.dis_on, 1'h1);
    chk("res off", po.rel_res_en, 1'h0);
    drv(16'h0ED8, 16'sh03E8, 1'h0, 1'h1, 6);
    chk("dis short", po.dis_on, 1'h0);
    drv(16'h0ED8, 16'sh0000, 1'h0, 1'h1, 12);
    chk("dis short rel", po.dis_on, 1'h1);
  endtask
  task automatic t_coc();
    drv(16'h0ED8, -16'sh00C8, 1'h1, 1'h0, 3);
    drv(16'h0ED8, 16'sh0000, 1'h1, 1'h0, 5);
    chk("chg coc glitch", po.chg_on, 1'h1);
    drv(16'h0ED8, -16'sh00C8, 1'h1, 1'h0, 15);
    chk("chg coc", po.chg_on, 1'h0);
    drv(16'h0ED8, 16'sh0000, 1'h1, 1'h0, 15);
    chk("chg coc hold", po.chg_on, 1'h0);
    drv(16'h0000, 16'sh0000, 1'h1, 1'h0, 6);
    chk("chg zero v", po.chg_on, 1'h1);
    drv(16'h0ED8, 16'sh0000, 1'h0, 1'h1, 12);
    chk("chg coc rel", po.chg_on, 1'h1);
  endtask
  task automatic t_ds();
    drv(16'h0960, -16'sh09C4, 1'h0, 1'h1, 7);
    chk("dis shortened", po.dis_on, 1'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    rst();
    t_oc();
    rst();
    t_od();
    rst();
    t_doc();
    rst();
    t_coc();
    rst();
    t_ds();
    stop_test();
  end
endmodule
